// ===== logic/csc_regs.svh
// Command codes, field positions, reset values and frequency constants of the slot config bank.
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

// Command codes with the direction bit cleared, except the real-time code 4D, which has it set.
`define CSC_CMD_TX_SLOT      8'h40
`define CSC_CMD_RX_SLOT      8'h42
`define CSC_CMD_CLK_SLOT     8'h44
`define CSC_CMD_CHIP_CFG     8'h46
`define CSC_CMD_CHAN_EN      8'h4A
`define CSC_CMD_RT_DATA      8'h4D
`define CSC_CMD_RT_MASK      8'h6C
`define CSC_CMD_DIR_STRIP    8'hFE
`define CSC_CMD_RT_STRIP     8'hFD
`define CSC_CMD_RW_BIT       0
`define CSC_CMD_RT_CLR_BIT   1

// Slot register fields.
`define CSC_SLOT_HWY_BIT     7
`define CSC_SLOT_NUM_MSB     6

// Clock slot register fields.
`define CSC_CLK_TAB_BIT      7
`define CSC_CLK_EDGE_BIT     6
`define CSC_CLK_RX_MSB       5
`define CSC_CLK_RX_LSB       3
`define CSC_CLK_TX_MSB       2

// Chip configuration fields.
`define CSC_CFG_IRQ_TYPE_BIT 7
`define CSC_CFG_CHOP_BIT     6
`define CSC_CFG_SIG_BIT      5
`define CSC_CFG_CLK_SRC_BIT  4
`define CSC_CFG_FREQ_MSB     3

// Channel enable and mode fields.
`define CSC_EN_RBE_BIT       6
`define CSC_EN_VOICE_OUT_IDLE_MODE_BIT     5
`define CSC_EN_LPM_BIT       4
`define CSC_EN_CHAN_MSB      3

// Reset values.
`define CSC_RST_CLK_SLOT     8'h00
`define CSC_RST_CHIP_CFG     8'h9A
`define CSC_RST_CHAN_EN      8'h0F
`define CSC_RST_RT_MASK      8'hFF
`define CSC_RST_FREQ_KHZ     14'h2000

// Master clock bases in kHz and chopper divisors.
`define CSC_FREQ_B0_KHZ      14'h0600
`define CSC_FREQ_B1_KHZ      14'h0608
`define CSC_FREQ_B2_KHZ      14'h0800
`define CSC_CHOP_DIV_SLOW    4'h8
`define CSC_CHOP_DIV_FAST    4'h7

`endif

// ===== logic/csc_pkg.sv
// Types shared by the slot config bank modules.
package csc_pkg;

    typedef struct packed {
        logic [7:0] tx;
        logic [7:0] rx;
        logic       tab;
    } csc_chan_state_t;

    typedef struct packed {
        logic        tx_edge;
        logic [2:0]  rx_off;
        logic [2:0]  tx_off;
        logic [7:0]  cfg;
        logic [3:0]  chan_en;
        logic        robbed_bit_en;
        logic        voice_out_idle_mode;
        logic        legacy_power_bit;
        logic [7:0]  mask;
        logic [7:0]  rt_prev;
        logic        pending;
        logic        rsp_valid;
        logic [7:0]  rsp_data;
        logic        irq_n;
        logic        irq_n_oe;
        logic [13:0] freq_khz;
        logic        freq_rsvd;
        logic [3:0]  chop_div;
        logic        robbed_active;
        logic        e1_allowed;
    } csc_state_t;

endpackage

// ===== logic/csc_chan_slot.sv
// Per-channel transmit slot, receive slot and dual-transmit storage.
`timescale 1ns/100ps
`include "csc_regs.svh"
module csc_chan_slot import csc_pkg::*; #(
    parameter logic [7:0] RESET_SLOT = 8'h00
) (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       resetn_i,
    // Write strobes and data
    input  wire logic       wr_tx_i,
    input  wire logic       wr_rx_i,
    input  wire logic       wr_tab_i,
    input  wire logic [7:0] data_i,
    // Stored values
    output logic      [7:0] tx_o,
    output logic      [7:0] rx_o,
    output logic            tab_o
);

    csc_chan_state_t st;
    csc_chan_state_t next_st;

    always_comb begin
        next_st = st;
        if (wr_tx_i) begin
            next_st.tx = data_i;
        end
        if (wr_rx_i) begin
            next_st.rx = data_i;
        end
        if (wr_tab_i) begin
            next_st.tab = data_i[`CSC_CLK_TAB_BIT];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st.tx  <= RESET_SLOT;
            st.rx  <= RESET_SLOT;
            st.tab <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign tx_o  = st.tx;
    assign rx_o  = st.rx;
    assign tab_o = st.tab;

endmodule

// ===== logic/csc_bank.sv
// Command-addressed slot and configuration register bank for one four-channel group.
`timescale 1ns/100ps
`include "csc_regs.svh"
module csc_bank import csc_pkg::*; (
    // Clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            resetn_i,
    // Decoded command port
    input  wire logic            cmd_valid_i,
    input  wire logic [7:0]      cmd_i,
    input  wire logic [7:0]      cmd_data_i,
    output logic                 rsp_valid_o,
    output logic      [7:0]      rsp_data_o,
    // Real-time inputs and coding state
    input  wire logic [3:0]      debounced_input_a_i,
    input  wire logic [3:0]      input_b_or_mux_i,
    input  wire logic            mu_law_sel_i,
    input  wire logic            e1_mux_req_i,
    // Interrupt pin
    output logic                 irq_n_o,
    output logic                 irq_n_oe_o,
    // Per-channel slot settings
    output logic [3:0][6:0]      tx_slot_number_o,
    output logic [3:0]           tx_highway_sel_o,
    output logic [3:0][6:0]      rx_slot_number_o,
    output logic [3:0]           rx_highway_sel_o,
    output logic [3:0]           dual_tx_en_o,
    // Global clock slot settings
    output logic                 tx_edge_sel_o,
    output logic      [2:0]      rx_bit_offset_o,
    output logic      [2:0]      tx_bit_offset_o,
    // Chip configuration
    output logic                 irq_output_type_o,
    output logic                 chopper_rate_sel_o,
    output logic      [3:0]      chopper_div_o,
    output logic                 highway_signaling_en_o,
    output logic                 master_clock_source_o,
    output logic                 e1_mux_allowed_o,
    output logic      [3:0]      master_freq_sel_o,
    output logic      [13:0]     master_freq_khz_o,
    output logic                 master_freq_reserved_o,
    // Channel enable and mode
    output logic                 robbed_bit_en_o,
    output logic                 robbed_bit_active_o,
    output logic                 voice_out_idle_mode_o,
    output logic                 legacy_power_bit_o,
    output logic      [3:0]      chan_cmd_en_o,
    output logic      [7:0]      realtime_bit_mask_o
);

    csc_state_t       st;
    csc_state_t       next_st;
    logic [3:0][7:0]  chan_tx;
    logic [3:0][7:0]  chan_rx;
    logic [3:0]       chan_tab;
    logic [3:0]       wr_tx;
    logic [3:0]       wr_rx;
    logic [3:0]       wr_tab;
    logic [7:0]       opc;
    logic             is_read;
    logic             any_en;
    logic [1:0]       sel_idx;
    logic [7:0]       rt_now;
    logic [7:0]       rt_change;
    logic             rt_hit;
    logic             rt_clr;
    logic [13:0]      base_khz;

    // Each of the four channels has its own slot storage instance, with its own reset slot.
    genvar c;
    generate
        for (c = 0; c < 4; c++) begin : g_chan
            csc_chan_slot #(
                .RESET_SLOT (8'(c))
            ) u_slot (
                .ref_clk_i (ref_clk_i),
                .resetn_i  (resetn_i),
                .wr_tx_i   (wr_tx[c]),
                .wr_rx_i   (wr_rx[c]),
                .wr_tab_i  (wr_tab[c]),
                .data_i    (cmd_data_i),
                .tx_o      (chan_tx[c]),
                .rx_o      (chan_rx[c]),
                .tab_o     (chan_tab[c])
            );
        end
    endgenerate

    // Real-time byte with channel 1 in the lowest pair, debounced bit below.
    assign rt_now = {input_b_or_mux_i[3], debounced_input_a_i[3],
                     input_b_or_mux_i[2], debounced_input_a_i[2],
                     input_b_or_mux_i[1], debounced_input_a_i[1],
                     input_b_or_mux_i[0], debounced_input_a_i[0]};

    assign opc     = cmd_i & `CSC_CMD_DIR_STRIP;
    assign is_read = cmd_i[`CSC_CMD_RW_BIT];
    assign any_en  = |st.chan_en;
    assign rt_hit  = cmd_valid_i && ((cmd_i & `CSC_CMD_RT_STRIP) == `CSC_CMD_RT_DATA);
    assign rt_clr  = rt_hit && cmd_i[`CSC_CMD_RT_CLR_BIT];

    // A channel read returns the lowest-numbered enabled channel.
    always_comb begin
        sel_idx = 2'h0;
        if (st.chan_en[0]) begin
            sel_idx = 2'h0;
        end else if (st.chan_en[1]) begin
            sel_idx = 2'h1;
        end else if (st.chan_en[2]) begin
            sel_idx = 2'h2;
        end else if (st.chan_en[3]) begin
            sel_idx = 2'h3;
        end
    end

    // Channel writes land in every enabled channel, so enables act as a broadcast set.
    always_comb begin
        wr_tx  = 4'h0;
        wr_rx  = 4'h0;
        wr_tab = 4'h0;
        if (cmd_valid_i && !is_read) begin
            if (opc == `CSC_CMD_TX_SLOT) begin
                wr_tx = st.chan_en;
            end
            if (opc == `CSC_CMD_RX_SLOT) begin
                wr_rx = st.chan_en;
            end
            if (opc == `CSC_CMD_CLK_SLOT) begin
                wr_tab = st.chan_en;
            end
        end
    end

    always_comb begin
        next_st           = st;
        next_st.rsp_valid = 1'b0;
        next_st.rt_prev   = rt_now;
        rt_change         = (rt_now ^ st.rt_prev) & ~st.mask;
        base_khz          = `CSC_FREQ_B0_KHZ;

        if (cmd_valid_i && !is_read) begin
            unique case (opc)
                `CSC_CMD_CLK_SLOT: begin
                    if (any_en) begin
                        next_st.tx_edge = cmd_data_i[`CSC_CLK_EDGE_BIT];
                        next_st.rx_off  = cmd_data_i[`CSC_CLK_RX_MSB:`CSC_CLK_RX_LSB];
                        next_st.tx_off  = cmd_data_i[`CSC_CLK_TX_MSB:0];
                    end
                end
                `CSC_CMD_CHIP_CFG: begin
                    next_st.cfg = cmd_data_i;
                end
                `CSC_CMD_CHAN_EN: begin
                    next_st.chan_en = cmd_data_i[`CSC_EN_CHAN_MSB:0];
                    next_st.legacy_power_bit     = cmd_data_i[`CSC_EN_LPM_BIT];
                    next_st.voice_out_idle_mode   = cmd_data_i[`CSC_EN_VOICE_OUT_IDLE_MODE_BIT];
                    next_st.robbed_bit_en     = cmd_data_i[`CSC_EN_RBE_BIT];
                end
                `CSC_CMD_RT_MASK: begin
                    next_st.mask = cmd_data_i;
                end
                default: begin
                end
            endcase
        end

        if (cmd_valid_i && is_read) begin
            unique case (opc)
                `CSC_CMD_TX_SLOT: begin
                    if (any_en) begin
                        next_st.rsp_valid = 1'b1;
                        next_st.rsp_data  = chan_tx[sel_idx];
                    end
                end
                `CSC_CMD_RX_SLOT: begin
                    if (any_en) begin
                        next_st.rsp_valid = 1'b1;
                        next_st.rsp_data  = chan_rx[sel_idx];
                    end
                end
                `CSC_CMD_CLK_SLOT: begin
                    if (any_en) begin
                        next_st.rsp_valid = 1'b1;
                        next_st.rsp_data  = {chan_tab[sel_idx], st.tx_edge,
                                             st.rx_off, st.tx_off};
                    end
                end
                `CSC_CMD_CHIP_CFG: begin
                    next_st.rsp_valid = 1'b1;
                    next_st.rsp_data  = st.cfg;
                end
                `CSC_CMD_CHAN_EN: begin
                    next_st.rsp_valid = 1'b1;
                    next_st.rsp_data  = {1'b0, st.robbed_bit_en, st.voice_out_idle_mode, st.legacy_power_bit, st.chan_en};
                end
                `CSC_CMD_RT_MASK: begin
                    next_st.rsp_valid = 1'b1;
                    next_st.rsp_data  = st.mask;
                end
                default: begin
                end
            endcase
        end

        // The real-time read is answered with no regard to channel enables.
        if (rt_hit) begin
            next_st.rsp_valid = 1'b1;
            next_st.rsp_data  = st.rt_prev;
        end

        // A fresh unmasked change in the clearing cycle keeps the interrupt pending.
        next_st.pending = (|rt_change) || (st.pending && !rt_clr);

        // Open-drain only pulls low; TTL drives both levels all the time.
        if (next_st.cfg[`CSC_CFG_IRQ_TYPE_BIT]) begin
            next_st.irq_n    = 1'b0;
            next_st.irq_n_oe = next_st.pending;
        end else begin
            next_st.irq_n    = !next_st.pending;
            next_st.irq_n_oe = 1'b1;
        end

        next_st.chop_div = next_st.cfg[`CSC_CFG_CHOP_BIT] ?
                           `CSC_CHOP_DIV_FAST : `CSC_CHOP_DIV_SLOW;

        // Frequency decode: low pair picks the base, high pair the power-of-two multiple.
        unique case (next_st.cfg[1:0])
            2'h0: base_khz = `CSC_FREQ_B0_KHZ;
            2'h1: base_khz = `CSC_FREQ_B1_KHZ;
            2'h2: base_khz = `CSC_FREQ_B2_KHZ;
            2'h3: base_khz = 14'h0000;
        endcase
        next_st.freq_rsvd = (next_st.cfg[1:0] == 2'h3) ||
                            (next_st.cfg[`CSC_CFG_FREQ_MSB:2] == 2'h3);
        if (next_st.freq_rsvd) begin
            next_st.freq_khz = 14'h0000;
        end else begin
            next_st.freq_khz = base_khz << next_st.cfg[`CSC_CFG_FREQ_MSB:2];
        end

        next_st.robbed_active = next_st.robbed_bit_en && mu_law_sel_i;
        next_st.e1_allowed    = next_st.cfg[`CSC_CFG_CLK_SRC_BIT] && e1_mux_req_i;
    end

    // All global settings live here, one copy per group instance.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st.tx_edge       <= 1'(`CSC_RST_CLK_SLOT >> `CSC_CLK_EDGE_BIT);
            st.rx_off        <= 3'h0;
            st.tx_off        <= 3'h0;
            st.cfg           <= `CSC_RST_CHIP_CFG;
            st.chan_en       <= 4'(`CSC_RST_CHAN_EN);
            st.robbed_bit_en           <= 1'b0;
            st.voice_out_idle_mode         <= 1'b0;
            st.legacy_power_bit           <= 1'b0;
            st.mask          <= `CSC_RST_RT_MASK;
            st.rt_prev       <= 8'h00;
            st.pending       <= 1'b0;
            st.rsp_valid     <= 1'b0;
            st.rsp_data      <= 8'h00;
            st.irq_n         <= 1'b0;
            st.irq_n_oe      <= 1'b0;
            st.freq_khz      <= `CSC_RST_FREQ_KHZ;
            st.freq_rsvd     <= 1'b0;
            st.chop_div      <= `CSC_CHOP_DIV_SLOW;
            st.robbed_active <= 1'b0;
            st.e1_allowed    <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    generate
        for (c = 0; c < 4; c++) begin : g_out
            assign tx_slot_number_o[c] = chan_tx[c][`CSC_SLOT_NUM_MSB:0];
            assign tx_highway_sel_o[c] = chan_tx[c][`CSC_SLOT_HWY_BIT];
            assign rx_slot_number_o[c] = chan_rx[c][`CSC_SLOT_NUM_MSB:0];
            assign rx_highway_sel_o[c] = chan_rx[c][`CSC_SLOT_HWY_BIT];
        end
    endgenerate

    assign dual_tx_en_o           = chan_tab;
    assign rsp_valid_o            = st.rsp_valid;
    assign rsp_data_o             = st.rsp_data;
    assign irq_n_o                = st.irq_n;
    assign irq_n_oe_o             = st.irq_n_oe;
    assign tx_edge_sel_o          = st.tx_edge;
    assign rx_bit_offset_o        = st.rx_off;
    assign tx_bit_offset_o        = st.tx_off;
    assign irq_output_type_o      = st.cfg[`CSC_CFG_IRQ_TYPE_BIT];
    assign chopper_rate_sel_o     = st.cfg[`CSC_CFG_CHOP_BIT];
    assign chopper_div_o          = st.chop_div;
    assign highway_signaling_en_o = st.cfg[`CSC_CFG_SIG_BIT];
    assign master_clock_source_o  = st.cfg[`CSC_CFG_CLK_SRC_BIT];
    assign e1_mux_allowed_o       = st.e1_allowed;
    assign master_freq_sel_o      = st.cfg[`CSC_CFG_FREQ_MSB:0];
    assign master_freq_khz_o      = st.freq_khz;
    assign master_freq_reserved_o = st.freq_rsvd;
    assign robbed_bit_en_o        = st.robbed_bit_en;
    assign robbed_bit_active_o    = st.robbed_active;
    assign voice_out_idle_mode_o  = st.voice_out_idle_mode;
    assign legacy_power_bit_o     = st.legacy_power_bit;
    assign chan_cmd_en_o          = st.chan_en;
    assign realtime_bit_mask_o    = st.mask;

endmodule

// ===== testbench/csc_bank_sva.sv
// Port-level assertions for the slot config bank.
`timescale 1ns/100ps
module csc_bank_sva import csc_pkg::*; (
    // Clock, reset and command port
    input wire logic       ref_clk_i,
    input wire logic       resetn_i,
    input wire logic       cmd_valid_i,
    input wire logic [7:0] cmd_i,
    input wire logic       rsp_valid_o,
    input wire logic [7:0] rsp_data_o,
    // Real-time inputs and interrupt pin
    input wire logic [3:0] debounced_input_a_i,
    input wire logic [3:0] input_b_or_mux_i,
    input wire logic       mu_law_sel_i,
    input wire logic       e1_mux_req_i,
    input wire logic       irq_n_o,
    input wire logic       irq_n_oe_o,
    // Configuration outputs
    input wire logic       irq_output_type_o,
    input wire logic       chopper_rate_sel_o,
    input wire logic [3:0] chopper_div_o,
    input wire logic       highway_signaling_en_o,
    input wire logic       master_clock_source_o,
    input wire logic       e1_mux_allowed_o,
    input wire logic [3:0] master_freq_sel_o,
    input wire logic       master_freq_reserved_o,
    input wire logic       robbed_bit_en_o,
    input wire logic       robbed_bit_active_o,
    input wire logic [3:0] chan_cmd_en_o,
    input wire logic [7:0] realtime_bit_mask_o
);
    wire logic [7:0] rt = {input_b_or_mux_i[3], debounced_input_a_i[3],
                           input_b_or_mux_i[2], debounced_input_a_i[2],
                           input_b_or_mux_i[1], debounced_input_a_i[1],
                           input_b_or_mux_i[0], debounced_input_a_i[0]};
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    a_read_answer: assert property (cmd_valid_i && cmd_i[0] &&
        (cmd_i[7:1] inside {7'h23, 7'h25, 7'h36}) |=> rsp_valid_o) else $error("read unanswered");
    a_cfg_readback: assert property (cmd_valid_i && cmd_i == 8'h47 |=> rsp_data_o ==
        {irq_output_type_o, chopper_rate_sel_o, highway_signaling_en_o, master_clock_source_o,
         master_freq_sel_o}) else $error("config readback wrong");
    a_chop_div: assert property (chopper_div_o == (chopper_rate_sel_o ? 4'h7 : 4'h8))
        else $error("chopper divisor wrong");
    a_freq_rsvd: assert property (master_freq_reserved_o ==
        (&master_freq_sel_o[1:0] || &master_freq_sel_o[3:2])) else $error("reserved flag wrong");
    a_clk_gate: assert property (cmd_valid_i && cmd_i == 8'h45 && chan_cmd_en_o == 4'h0
        |=> !rsp_valid_o) else $error("clock slot read without enable");
    a_rt_read: assert property (cmd_valid_i && (cmd_i & 8'hFD) == 8'h4D
        |=> rsp_valid_o && rsp_data_o == $past(rt, 2)) else $error("real-time read wrong");
    a_irq_raise: assert property (((rt ^ $past(rt)) & ~realtime_bit_mask_o) != 8'h00
        |=> irq_n_oe_o && !irq_n_o) else $error("unmasked change without interrupt");
    a_irq_clear: assert property (cmd_valid_i && cmd_i == 8'h4F && irq_output_type_o &&
        ((rt ^ $past(rt)) & ~realtime_bit_mask_o) == 8'h00 |=> !irq_n_oe_o)
        else $error("interrupt not cleared");
    a_robbed_gate: assert property (robbed_bit_active_o ==
        (robbed_bit_en_o && $past(mu_law_sel_i))) else $error("robbed-bit gating wrong");
    a_e1_gate: assert property (e1_mux_allowed_o ==
        (master_clock_source_o && $past(e1_mux_req_i))) else $error("E1 gating wrong");
    c_clear: cover property (cmd_valid_i && cmd_i == 8'h4F);
    c_irq: cover property ($rose(irq_n_oe_o));
    c_gated: cover property (cmd_valid_i && cmd_i == 8'h45 && chan_cmd_en_o == 4'h0);
    c_set_clear: cover property (cmd_valid_i && cmd_i == 8'h4F &&
        ((rt ^ $past(rt)) & ~realtime_bit_mask_o) != 8'h00);
endmodule

bind csc_bank csc_bank_sva u_sva (.ref_clk_i, .resetn_i, .cmd_valid_i, .cmd_i, .rsp_valid_o,
    .rsp_data_o, .debounced_input_a_i, .input_b_or_mux_i, .mu_law_sel_i, .e1_mux_req_i,
    .irq_n_o, .irq_n_oe_o, .irq_output_type_o, .chopper_rate_sel_o, .chopper_div_o,
    .highway_signaling_en_o, .master_clock_source_o, .e1_mux_allowed_o, .master_freq_sel_o,
    .master_freq_reserved_o, .robbed_bit_en_o, .robbed_bit_active_o, .chan_cmd_en_o,
    .realtime_bit_mask_o);

// ===== testbench/csc_host.sv
// Host model that issues command and data byte pairs to the bank.
`timescale 1ns/100ps
module csc_host (
    // Clock and answer
    input  wire logic       ref_clk_i,
    input  wire logic       rsp_valid_i,
    input  wire logic [7:0] rsp_data_i,
    // Request
    output logic            cmd_valid_o,
    output logic      [7:0] cmd_o,
    output logic      [7:0] cmd_data_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o       = 8'h00;
        cmd_data_o  = 8'h00;
    end
    // Between requests the byte lines show the inverse so stale values cannot match.
    task automatic xfer(input logic [7:0] c, input logic [7:0] d, output logic got,
                        output logic [7:0] q);
        @(posedge ref_clk_i);
        #1;
        cmd_valid_o = 1'b1;
        cmd_o       = c;
        cmd_data_o  = (c == 8'h4A) ? {1'b0, d[6:0]} : d;
        @(posedge ref_clk_i);
        #1;
        got         = rsp_valid_i;
        q           = rsp_data_i;
        cmd_valid_o = 1'b0;
        cmd_o       = ~c;
        cmd_data_o  = ~d;
    endtask
endmodule

// ===== testbench/csc_bank_tb.sv
// Self-checking bench for the slot config bank.
`timescale 1ns/100ps
module csc_bank_tb import csc_pkg::*; ;
    logic ref_clk_i = 1'b0, resetn_i = 1'b0, mu_law_sel_i = 1'b0, e1_mux_req_i = 1'b0;
    logic [3:0] debounced_input_a_i = 4'h0, input_b_or_mux_i = 4'h0;
    logic cmd_valid_i, rsp_valid_o, irq_n_o, irq_n_oe_o, tx_edge_sel_o, irq_output_type_o;
    logic [7:0] cmd_i, cmd_data_i, rsp_data_o, realtime_bit_mask_o, c, q;
    logic [3:0][6:0] tx_slot_number_o, rx_slot_number_o;
    logic [3:0] tx_highway_sel_o, rx_highway_sel_o, dual_tx_en_o, chopper_div_o;
    logic [3:0] master_freq_sel_o, chan_cmd_en_o;
    logic [2:0] rx_bit_offset_o, tx_bit_offset_o;
    logic chopper_rate_sel_o, highway_signaling_en_o, master_clock_source_o, e1_mux_allowed_o;
    logic master_freq_reserved_o, robbed_bit_en_o, robbed_bit_active_o, got;
    logic voice_out_idle_mode_o, legacy_power_bit_o;
    logic [13:0] master_freq_khz_o;
    logic [15:0] e;
    int n_fail = 0;
    int check_count = 0;

    always #2.5 ref_clk_i = ~ref_clk_i;

    csc_bank u_dut (.ref_clk_i, .resetn_i, .cmd_valid_i, .cmd_i, .cmd_data_i, .rsp_valid_o,
        .rsp_data_o, .debounced_input_a_i, .input_b_or_mux_i, .mu_law_sel_i, .e1_mux_req_i,
        .irq_n_o, .irq_n_oe_o, .tx_slot_number_o, .tx_highway_sel_o, .rx_slot_number_o,
        .rx_highway_sel_o, .dual_tx_en_o, .tx_edge_sel_o, .rx_bit_offset_o, .tx_bit_offset_o,
        .irq_output_type_o, .chopper_rate_sel_o, .chopper_div_o, .highway_signaling_en_o,
        .master_clock_source_o, .e1_mux_allowed_o, .master_freq_sel_o, .master_freq_khz_o,
        .master_freq_reserved_o, .robbed_bit_en_o, .robbed_bit_active_o,
        .voice_out_idle_mode_o, .legacy_power_bit_o, .chan_cmd_en_o, .realtime_bit_mask_o);

    csc_host u_host (.ref_clk_i, .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o),
        .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i), .cmd_data_o(cmd_data_i));

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
        check_count++;
        if (sn !== ex) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, ex, sn);
        end
    endtask
    task automatic wr(input logic [7:0] cm, input logic [7:0] d);
        u_host.xfer(cm, d, got, q);
    endtask
    task automatic rd(input logic [7:0] cm, input logic [7:0] ex);
        u_host.xfer(cm, 8'h00, got, q);
        chk("rsp_valid", 1, got);
        chk("rsp_data", ex, q);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #50000;
        n_fail++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge ref_clk_i);
        #1 resetn_i = 1'b1;
        chk("irq_oe", 0, irq_n_oe_o);
        rd(8'h47, 8'h9A);
        chk("khz", 8192, master_freq_khz_o);
        rd(8'h4B, 8'h0F);
        rd(8'h45, 8'h00);
        rd(8'h6D, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            wr(8'h4A, 8'h01 << i);
            rd(8'h41, i[7:0]);
            rd(8'h43, i[7:0]);
        end
        wr(8'h40, 8'hFF);
        chk("tx_slot", {7'h7F, 7'h02, 7'h01, 7'h00}, tx_slot_number_o);
        chk("tx_hwy", 4'h8, tx_highway_sel_o);
        wr(8'h42, 8'h85);
        rd(8'h43, 8'h85);
        chk("rx", {1'b1, 7'h05}, {rx_highway_sel_o[3], rx_slot_number_o[3]});
        wr(8'h4A, 8'h0F);
        rd(8'h41, 8'h00);
        wr(8'h40, 8'h00);
        chk("tx_all", 32'h0, {tx_highway_sel_o, tx_slot_number_o});
        wr(8'h44, 8'hEB);
        chk("clk", {4'hF, 1'b1, 3'h5, 3'h3},
            {dual_tx_en_o, tx_edge_sel_o, rx_bit_offset_o, tx_bit_offset_o});
        rd(8'h45, 8'hEB);
        wr(8'h4A, 8'h00);
        u_host.xfer(8'h45, 8'h00, got, q);
        chk("gated", 0, got);
        wr(8'h44, 8'h00);
        rd(8'h47, 8'h9A);
        rd(8'h4D, 8'h00);
        wr(8'h4A, 8'h0F);
        rd(8'h45, 8'hEB);
        for (int i = 0; i < 32; i++) begin
            c = {i[4], i[4], ~i[4], i[4], i[3:0]};
            e1_mux_req_i = i[0];
            wr(8'h46, c);
            e = (i[1:0] == 2'h0) ? 16'd1536 : (i[1:0] == 2'h1) ? 16'd1544 : 16'd2048;
            e = (&i[1:0] || &i[3:2]) ? 16'd0 : e << i[3:2];
            chk("khz", e, master_freq_khz_o);
            e = {2'h0, c, (c[6] ? 4'h7 : 4'h8), (&c[1:0] || &c[3:2]), c[4] & i[0]};
            chk("cfg", e, {irq_output_type_o, chopper_rate_sel_o,
                highway_signaling_en_o,
                 master_clock_source_o, master_freq_sel_o, chopper_div_o,
                 master_freq_reserved_o, e1_mux_allowed_o});
        end
        wr(8'h46, 8'h9A);
        wr(8'h4A, 8'hFF);
        chk("mode", 8'hBF, {robbed_bit_en_o, robbed_bit_active_o,
            voice_out_idle_mode_o, legacy_power_bit_o, chan_cmd_en_o});
        mu_law_sel_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1 chk("robbed", 1, robbed_bit_active_o);
        wr(8'h4A, 8'h0F);
        debounced_input_a_i = 4'h5;
        input_b_or_mux_i = 4'h3;
        rd(8'h4D, 8'h1B);
        chk("irq_oe", 0, irq_n_oe_o);
        wr(8'h6C, 8'hFE);
        chk("mask", 8'hFE, realtime_bit_mask_o);
        debounced_input_a_i = 4'h4;
        repeat (2) @(posedge ref_clk_i);
        #1 chk("irq", 2'b01, {irq_n_o, irq_n_oe_o});
        rd(8'h4D, 8'h1A);
        chk("irq_oe", 1, irq_n_oe_o);
        rd(8'h4F, 8'h1A);
        chk("irq_oe", 0, irq_n_oe_o);
        wr(8'h46, 8'h1A);
        chk("ttl", 2'b11, {irq_n_o, irq_n_oe_o});
        debounced_input_a_i = 4'h5;
        repeat (2) @(posedge ref_clk_i);
        #1 chk("ttl", 2'b01, {irq_n_o, irq_n_oe_o});
        // A fresh unmasked change in the clearing cycle must keep the interrupt pending.
        fork
            rd(8'h4F, 8'h1B);
            begin
                @(posedge ref_clk_i);
                #1 debounced_input_a_i = 4'h4;
            end
        join
        chk("set_wins", 2'b01, {irq_n_o, irq_n_oe_o});
        rd(8'h4F, 8'h1A);
        chk("ttl", 2'b11, {irq_n_o, irq_n_oe_o});
        test_done();
    end
endmodule
